// File: core/acc_pkg.sv
/*
 Constants, register map and rule summary for the converter
 sequencing block. Assumes a classic Wishbone bus with 32-bit data.
*/
// How it works
// - Standby halts every conversion activity
// - Clearing enable bit 7 stops conversion
// - Result read served before new store
// - Trigger edges ignored while converting or storing
// - Mode/channel write beats completion, no store
// - Channel write leaves end flag untouched
// - About one tenth of period samples input
// - Each conversion yields a 10-bit code
// - Trigger mode: one conversion per edge
// - Software mode restarts same channel continuously
// - Edge field: none, fall, rise, both
package acc_pkg;

	// ************************************************************
	// Register offsets (byte addresses)
	// ************************************************************
	localparam logic [3:0] ACC_OFS_MODE = 4'h0;
	localparam logic [3:0] ACC_OFS_CHAN = 4'h4;
	localparam logic [3:0] ACC_OFS_RESULT = 4'h8;
	localparam logic [3:0] ACC_OFS_FLAG = 4'hC;

	// ************************************************************
	// Fields and reset values
	// ************************************************************
	localparam int ACC_BIT_ENABLE = 7;
	localparam int ACC_BIT_HWTRIG = 6;
	localparam int ACC_BIT_EDGE_HI = 2;
	localparam int ACC_BIT_EDGE_LO = 1;
	localparam int ACC_BIT_END_FLAG = 0;
	localparam logic [7:0] ACC_MODE_RESET = 8'h00;
	localparam logic [2:0] ACC_CHAN_RESET = 3'h0;
	localparam logic [9:0] ACC_RESULT_RESET = 10'h000;

	localparam logic [1:0] ACC_EDGE_NONE = 2'h0;
	localparam logic [1:0] ACC_EDGE_FALL = 2'h1;
	localparam logic [1:0] ACC_EDGE_RISE = 2'h2;
	localparam logic [1:0] ACC_EDGE_BOTH = 2'h3;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int ACC_CONV_CYCLES = 120;
	localparam int ACC_SAMPLE_DIV = 10;

	typedef enum logic [1:0] {
		ACC_IDLE,
		ACC_SAMPLE,
		ACC_COMPARE,
		ACC_STORE
	} acc_state_t;

endpackage

// File: core/acc_conv.sv
/*
 Sequencing and arbitration logic of a 10-bit successive
 approximation converter with Wishbone register access.
 Assumes an analog comparator outside, a synchronous system clock and
 an external trigger pin asynchronous to that clock.
*/
// Added by the designer: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module acc_conv
	import acc_pkg::*;
#(
	parameter int RES_BITS = 10,
	parameter int CONV_CYCLES = ACC_CONV_CYCLES,
	parameter int CHAN_BITS = 3
) (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic CLK_EN,
	input wire logic STANDBY,
	input wire logic EXT_TRIGGER,
	input wire logic CMP_HIGH,
	output logic [RES_BITS-1:0] DAC_CODE,
	output logic SAMPLING,
	output logic [CHAN_BITS-1:0] ANALOG_SEL,
	output logic CONVERTING,
	output logic CONV_END_REQ,
	output logic IRQ,
	input wire logic WB_CYC,
	input wire logic WB_STB,
	input wire logic WB_WE,
	input wire logic [3:0] WB_ADR,
	input wire logic [3:0] WB_SEL,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK
);

	localparam int SAMPLE_CYCLES = CONV_CYCLES / ACC_SAMPLE_DIV;
	localparam int CNT_W = $clog2(CONV_CYCLES + 1);
	localparam logic [CNT_W-1:0] SAMPLE_END = CNT_W'(SAMPLE_CYCLES - 1);

	initial begin
		if (RES_BITS != 10 || CHAN_BITS < 1 || CHAN_BITS > 8 ||
			SAMPLE_CYCLES < 1 || CONV_CYCLES - SAMPLE_CYCLES < RES_BITS)
			$error("acc_conv: unsupported parameters");
	end

	// ************************************************************
	// Registers and bus decode
	// ************************************************************
	logic [7:0] mode;
	logic [CHAN_BITS-1:0] chan;
	logic [RES_BITS-1:0] result;
	logic end_flag;
	logic irq_en;
	logic bus_req;
	logic wr_lane0;
	logic wr_mode;
	logic wr_chan;
	logic wr_flag;
	logic rd_result;
	logic store_ok;
	logic store_pending;
	logic [RES_BITS-1:0] pend_val;

	assign bus_req = WB_CYC && WB_STB && !WB_ACK;
	assign wr_lane0 = bus_req && WB_WE && WB_SEL[0];
	assign wr_mode = wr_lane0 && WB_ADR == ACC_OFS_MODE;
	assign wr_chan = wr_lane0 && WB_ADR == ACC_OFS_CHAN;
	assign wr_flag = wr_lane0 && WB_ADR == ACC_OFS_FLAG;
	assign rd_result = bus_req && !WB_WE && WB_ADR == ACC_OFS_RESULT;

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			WB_ACK <= 1'b0;
			WB_DAT_O <= 32'h0000_0000;
		end else if (CLK_EN) begin
			WB_ACK <= bus_req;
			if (bus_req && !WB_WE) begin
				case (WB_ADR)
					ACC_OFS_MODE: WB_DAT_O <= {24'h000000, mode};
					ACC_OFS_CHAN: WB_DAT_O <= 32'(chan);
					ACC_OFS_RESULT: WB_DAT_O <= 32'(result);
					ACC_OFS_FLAG: WB_DAT_O <= {30'h0, irq_en, end_flag};
					default: WB_DAT_O <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			mode <= ACC_MODE_RESET;
			chan <= CHAN_BITS'(ACC_CHAN_RESET);
			irq_en <= 1'b0;
		end else if (CLK_EN) begin
			if (wr_mode)
				mode <= WB_DAT_I[7:0];
			if (wr_chan)
				chan <= WB_DAT_I[CHAN_BITS-1:0];
			if (wr_flag)
				irq_en <= WB_DAT_I[1];
		end
	end

	// ************************************************************
	// Trigger synchroniser and edge select
	// ************************************************************
	logic trig_s1;
	logic trig_s2;
	logic trig_s3;
	logic trig_edge;

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			trig_s1 <= 1'b0;
			trig_s2 <= 1'b0;
			trig_s3 <= 1'b0;
		end else if (CLK_EN) begin
			trig_s1 <= EXT_TRIGGER;
			trig_s2 <= trig_s1;
			trig_s3 <= trig_s2;
		end
	end

	always_comb begin
		case (mode[ACC_BIT_EDGE_HI:ACC_BIT_EDGE_LO])
			ACC_EDGE_FALL: trig_edge = trig_s3 && !trig_s2;
			ACC_EDGE_RISE: trig_edge = !trig_s3 && trig_s2;
			ACC_EDGE_BOTH: trig_edge = trig_s3 != trig_s2;
			default: trig_edge = 1'b0;
		endcase
	end

	// ************************************************************
	// Conversion sequencer
	// ************************************************************
	acc_state_t state;
	logic [CNT_W-1:0] cnt;
	logic [RES_BITS-1:0] sar;
	logic [RES_BITS-1:0] bit_ptr;
	logic run;
	logic hw_mode;
	logic setup_wr;
	logic start;
	logic done;

	assign run = mode[ACC_BIT_ENABLE] && !STANDBY;
	assign hw_mode = mode[ACC_BIT_HWTRIG];
	assign setup_wr = wr_mode || wr_chan;
	// Edges only counted when idle, so busy and store cycles drop them
	assign start = run && !setup_wr &&
		(hw_mode ? (state == ACC_IDLE && trig_edge) :
		state == ACC_IDLE);
	assign done = state == ACC_STORE;

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			state <= ACC_IDLE;
			cnt <= '0;
			sar <= '0;
			bit_ptr <= '0;
		end else if (CLK_EN) begin
			if (!run || setup_wr) begin
				state <= ACC_IDLE;
				cnt <= '0;
			end else begin
				case (state)
					ACC_IDLE: begin
						if (start) begin
							state <= ACC_SAMPLE;
							cnt <= '0;
						end
					end
					ACC_SAMPLE: begin
						cnt <= cnt + 1'b1;
						if (cnt == SAMPLE_END) begin
							state <= ACC_COMPARE;
							sar <= {1'b1, {(RES_BITS-1){1'b0}}};
							bit_ptr <= {1'b1, {(RES_BITS-1){1'b0}}};
						end
					end
					ACC_COMPARE: begin
						cnt <= cnt + 1'b1;
						if (!bit_ptr[0] || cnt == CNT_W'(CONV_CYCLES - 2)) begin
							if (bit_ptr != '0) begin
								sar <= (CMP_HIGH ? sar : sar & ~bit_ptr) |
									(bit_ptr >> 1);
								bit_ptr <= bit_ptr >> 1;
							end
						end
						if (cnt == CNT_W'(CONV_CYCLES - 2))
							state <= ACC_STORE;
					end
					ACC_STORE: begin
						// Software mode rolls straight into the next one
						cnt <= '0;
						state <= hw_mode ? ACC_IDLE : ACC_SAMPLE;
					end
					default: state <= ACC_IDLE;
				endcase
			end
		end
	end

	// ************************************************************
	// Result store, end flag and request
	// ************************************************************
	assign store_ok = done && run && !setup_wr;

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			result <= ACC_RESULT_RESET;
			store_pending <= 1'b0;
			pend_val <= '0;
			CONV_END_REQ <= 1'b0;
		end else if (CLK_EN) begin
			CONV_END_REQ <= store_ok;
			if (setup_wr) begin
				store_pending <= 1'b0;
			end else if (store_ok && rd_result) begin
				store_pending <= 1'b1;
				pend_val <= sar;
			end else if (store_ok) begin
				result <= sar;
			end else if (store_pending) begin
				result <= pend_val;
				store_pending <= 1'b0;
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N)
			end_flag <= 1'b0;
		else if (CLK_EN) begin
			// Set wins; channel writes never touch it
			if (store_ok)
				end_flag <= 1'b1;
			else if (wr_flag && WB_DAT_I[ACC_BIT_END_FLAG])
				end_flag <= 1'b0;
		end
	end

	assign IRQ = end_flag && irq_en;
	assign CONVERTING = state != ACC_IDLE;
	assign SAMPLING = state == ACC_SAMPLE;
	assign DAC_CODE = sar;
	assign ANALOG_SEL = chan;

endmodule

`default_nettype wire

// File: verif/acc_cmp_model.sv
/* Comparator and sample-hold model for acc_conv.
 Assumes vin is steady enough to be held while sampling is high. */
`timescale 1ns/1ps
`default_nettype none
module acc_cmp_model (
	input wire logic clk,
	input wire logic sampling,
	input wire logic [9:0] vin,
	input wire logic [9:0] dac_code,
	output logic cmp_high
);
	logic [9:0] held;
	always_ff @(posedge clk) begin
		// Input only held by the sampler, never read as a digital port
		if (sampling) held <= vin;
	end
	assign cmp_high = held >= dac_code;
endmodule
`default_nettype wire

// File: verif/acc_conv_props.sv
/* Port checker for acc_conv.
 Assumes a bind from tb and CLK_EN held high. */
`timescale 1ns/1ps
`default_nettype none
module acc_conv_props
	import acc_pkg::*;
#(
	parameter int CONV_CYCLES = ACC_CONV_CYCLES
) (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic STANDBY,
	input wire logic WB_CYC,
	input wire logic WB_STB,
	input wire logic WB_WE,
	input wire logic [3:0] WB_ADR,
	input wire logic [3:0] WB_SEL,
	input wire logic [31:0] WB_DAT_I,
	input wire logic WB_ACK,
	input wire logic SAMPLING,
	input wire logic CONVERTING,
	input wire logic CONV_END_REQ
);
	int sc;
	int cc;
	logic tk;
	logic wset;
	assign tk = WB_CYC && WB_STB && !WB_ACK;
	assign wset = tk && WB_WE && WB_SEL[0]
		&& (WB_ADR == ACC_OFS_MODE || WB_ADR == ACC_OFS_CHAN);
	always_ff @(posedge SYS_CLK) begin
		sc <= SAMPLING ? sc + 1 : 0;
	end
	always_ff @(posedge SYS_CLK) begin
		cc <= (CONVERTING && !CONV_END_REQ) ? cc + 1 : 0;
	end
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);
	ack_one_a: assert property (tk |=> WB_ACK ##1 !WB_ACK)
		else $error("ack not one cycle");
	standby_halt_a: assert property (STANDBY ##1 STANDBY |-> !CONVERTING)
		else $error("converting in standby");
	stop_conv_a: assert property (wset && WB_ADR == ACC_OFS_MODE
		&& !WB_DAT_I[ACC_BIT_ENABLE] |=> !CONVERTING [*3])
		else $error("no stop");
	write_wins_a: assert property (wset |=> !CONV_END_REQ)
		else $error("request after setup write");
	req_pulse_a: assert property (CONV_END_REQ |=> !CONV_END_REQ)
		else $error("request too long");
	store_state_a: assert property (CONV_END_REQ |-> !CONVERTING || SAMPLING)
		else $error("request not at conversion boundary");
	sample_len_a: assert property ($fell(SAMPLING) && CONVERTING
		|-> sc == CONV_CYCLES / ACC_SAMPLE_DIV)
		else $error("sample length");
	conv_len_a: assert property (CONV_END_REQ
		|-> cc >= CONV_CYCLES - 2 && cc <= CONV_CYCLES)
		else $error("conversion length");
	cover property (CONV_END_REQ);
	cover property (STANDBY && CONVERTING);
	cover property (wset && CONVERTING);
endmodule
`default_nettype wire

// File: verif/tb.sv
/* Self-checking bench for acc_conv over Wishbone.
 Assumes the comparator model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb import acc_pkg::*;;
	logic clk = 0, rst_n = 0, stby = 0, trg = 0, cyc = 0, stb = 0, we = 0;
	logic smp, cmp, conv, req, irq, ack;
	logic [3:0] adr = 0, sel = 4'hF;
	logic [31:0] di = 0, dout, rdat;
	logic [9:0] dac, vin = 10'h2A5;
	logic [2:0] asel;
	int mismatches = 0, n_tests = 0, ends = 0;
	acc_conv #(.CONV_CYCLES(40)) i_acc_conv(.SYS_CLK(clk), .RST_N(rst_n),
		.CLK_EN(1'b1), .STANDBY(stby), .EXT_TRIGGER(trg), .CMP_HIGH(cmp),
		.DAC_CODE(dac), .SAMPLING(smp), .ANALOG_SEL(asel), .CONVERTING(conv),
		.CONV_END_REQ(req), .IRQ(irq), .WB_CYC(cyc), .WB_STB(stb),
		.WB_WE(we), .WB_ADR(adr), .WB_SEL(sel), .WB_DAT_I(di),
		.WB_DAT_O(dout), .WB_ACK(ack));
	acc_cmp_model i_acc_cmp_model(.clk(clk), .sampling(smp), .vin(vin),
		.dac_code(dac), .cmp_high(cmp));
	initial forever #2 clk = ~clk;
	always @(posedge clk) if (req === 1'b1) ends <= ends + 1;
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %0t value mismatch", $time);
		end
	endtask
	task xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		di <= d;
		do @(posedge clk); while (ack !== 1'b1);
		rdat = dout;
		cyc <= 0;
		stb <= 0;
		@(posedge clk);
	endtask
	task rd(input logic [3:0] a, input logic [31:0] e);
		xfer(0, a, 0);
		chk(rdat, e);
	endtask
	task wend(input int n);
		int s;
		s = ends;
		while (ends < s + n) @(posedge clk);
	endtask
	task finish_test;
		if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk);
		mismatches++;
		finish_test;
	end
	initial begin
		logic [1:0] e;
		int s;
		repeat (8) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		rd(ACC_OFS_MODE, 0);
		rd(4'h2, 0);
		xfer(1, ACC_OFS_MODE, 32'h80);
		wend(2);
		rd(ACC_OFS_RESULT, 32'h2A5);
		xfer(1, ACC_OFS_CHAN, 32'h5);
		chk(asel, 5);
		sel <= 4'hE;
		xfer(1, ACC_OFS_CHAN, 32'h2);
		sel <= 4'hF;
		chk(asel, 5);
		rd(ACC_OFS_FLAG, 1);
		xfer(1, ACC_OFS_MODE, 0);
		repeat (50) @(posedge clk);
		chk(conv, 0);
		xfer(1, ACC_OFS_FLAG, 2);
		chk(irq, 1);
		xfer(1, ACC_OFS_FLAG, 3);
		chk(irq, 0);
		xfer(1, ACC_OFS_MODE, 32'h80);
		wend(1);
		chk(irq, 1);
		xfer(1, ACC_OFS_FLAG, 1);
		wend(1);
		chk(irq, 0);
		rd(ACC_OFS_FLAG, 1);
		stby <= 1;
		repeat (10) @(posedge clk);
		chk(conv, 0);
		stby <= 0;
		vin <= 10'h3FF;
		wend(2);
		rd(ACC_OFS_RESULT, 32'h3FF);
		xfer(1, ACC_OFS_MODE, 0);
		for (int i = 0; i < 5; i++) begin
			e = (i > 3) ? 2'h3 : 2'(i);
			xfer(1, ACC_OFS_MODE, 32'hC0 | (32'(e) << 1));
			s = ends;
			trg <= 1;
			repeat (i > 3 ? 10 : 60) @(posedge clk);
			trg <= 0;
			repeat (80) @(posedge clk);
			chk(ends - s, (i > 3) ? 32'h1 : 32'(e[0]) + 32'(e[1]));
		end
		finish_test;
	end
endmodule
bind acc_conv acc_conv_props #(.CONV_CYCLES(CONV_CYCLES)) i_acc_conv_props(
	.SYS_CLK(SYS_CLK), .RST_N(RST_N), .STANDBY(STANDBY), .WB_CYC(WB_CYC),
	.WB_STB(WB_STB), .WB_WE(WB_WE), .WB_ADR(WB_ADR), .WB_SEL(WB_SEL),
	.WB_DAT_I(WB_DAT_I), .WB_ACK(WB_ACK), .SAMPLING(SAMPLING),
	.CONVERTING(CONVERTING), .CONV_END_REQ(CONV_END_REQ));
`default_nettype wire
